// [logic/lpmc_pkg.sv]
// Constants and types for the low-power mode controller
package lpmc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_CONFIG_ONE = 8'h00;
  localparam logic [7:0] ADDR_CONFIG_TWO = 8'h04;
  localparam logic [7:0] ADDR_PLL_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASKS  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG1_STOP_EN   = 0;
  localparam int CFG1_SHORT_REC = 1;
  localparam int CFG1_UV_STOP   = 2;
  localparam int CFG1_UV_RST_EN = 3;
  localparam int CFG1_UV_EN     = 4;
  localparam int CFG1_WDOG_EN   = 5;
  localparam int CFG2_OSC_RUN   = 0;
  localparam int PLL_BASE_SEL   = 0;
  localparam int PLL_POWER_ON   = 1;
  localparam int MSK_EXT        = 0;
  localparam int MSK_KBD        = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [5:0] CFG1_RESET = 6'h10;
  localparam logic       CFG2_RESET = 1'h0;
  localparam logic [1:0] PLL_RESET  = 2'h0;
  localparam logic [1:0] MSK_RESET  = 2'h0;

  // ************************************************************
  // Wake vectors
  // ************************************************************
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_EXT   = 16'hfffa;
  localparam logic [15:0] VEC_KBD   = 16'hffe0;
  localparam logic [15:0] VEC_TBM   = 16'hffdc;

  // ************************************************************
  // Stop recovery timing in crystal clock cycles
  // ************************************************************
  localparam int          REC_LONG_CYC  = 4096;
  localparam int          REC_SHORT_CYC = 32;
  localparam logic [11:0] REC_LONG_LOAD  = 12'(REC_LONG_CYC - 1);
  localparam logic [11:0] REC_SHORT_LOAD = 12'(REC_SHORT_CYC - 1);

  // ************************************************************
  // Power states
  // ************************************************************
  typedef enum logic [1:0] {
    LPMC_RUN     = 2'b00,
    LPMC_WAIT    = 2'b01,
    LPMC_STOP    = 2'b10,
    LPMC_RECOVER = 2'b11
  } lpmc_state_e;

endpackage : lpmc_pkg

// [logic/low_power_mode_control.sv]
// Low-power wait and stop mode controller with APB configuration
//
// Summary of operation
// - Wait stops core clock, bus clock runs
// - Stop halts core; bus too unless oscillator kept
// - Wait/stop clear mask; reset wake sets it
// - Stop without osc keep: oscillator, PLL, clocks off
// - Stop clears base clock select; stays clear
// - Stop with osc keep: PLL off, oscillator on
// - Stop gates watchdog clock, clears prescaler
// - Stop only honoured when stop enable set
// - Converter aborts in stop, resumes after interrupt
// - Reset pin low in stop resets, reset vector
// - External or keyboard falling edge wakes stop
// - Timebase rollover wakes with timebase vector
// - Recovery holds clocks off 4096 crystal cycles
// - Short recovery bit shortens delay to 32
// - Timebase runs in stop only with osc kept
// - Timebase register inaccessible in wait and stop
// - Interrupt units active; wake only when unmasked
// - Undervoltage monitor resets and wakes in stop only with its stop and reset enables set
// - Serial port idle in stop; reset exit aborts
// - Timers freeze in stop, resume after interrupt
// - Watchdog counts in wait, resets on timeout
`timescale 1ns/1ps

module low_power_mode_control (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        waitExec,
  input  wire logic        stopExec,
  input  wire logic        extIrqPin,
  input  wire logic [3:0]  kbdPins,
  input  wire logic        rstPin_n,
  input  wire logic        lowVoltage,
  input  wire logic        tbmRollover,
  input  wire logic        periphIrq,
  input  wire logic        watchdogTimeout,
  output logic             coreClkEn,
  output logic             busClkEn,
  output logic             oscEnable,
  output logic             pllEnable,
  output logic             genClocksOn,
  output logic             watchdogClkEn,
  output logic             prescaleClear,
  output logic             converterActive,
  output logic             converterAbort,
  output logic             timebaseActive,
  output logic             timebaseAccess,
  output logic             timerRun,
  output logic             serialRun,
  output logic             serialReset,
  output logic             deviceReset,
  output logic             intMask,
  output logic             vectorValid,
  output logic      [15:0] vectorAddr,
  output logic             baseClockSelect,
  output logic             pllPowerOn
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Two stages per pin before any logic reads it; reset loads idle
  // levels so that no false falling edge follows reset
  logic [6:0] syncA;
  logic [6:0] syncB;
  logic [6:0] syncPrev;

  always_ff @(posedge clk) begin
    if (srst) begin
      syncA    <= 7'h7f;
      syncB    <= 7'h7f;
      syncPrev <= 7'h7f;
    end else begin
      syncA    <= {~lowVoltage, rstPin_n, kbdPins, extIrqPin};
      syncB    <= syncA;
      syncPrev <= syncB;
    end
  end

  wire       extFall  = syncPrev[0] & ~syncB[0];
  wire [3:0] kbdFallV = syncPrev[4:1] & ~syncB[4:1];
  wire       kbdFall  = |kbdFallV;
  wire       rstLow   = ~syncB[5];
  wire       uvLow    = ~syncB[6];

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [5:0]  configRegOne;
  logic        oscRunInStop;
  logic [1:0]  irqMasks;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  lpmc_pkg::lpmc_state_e state;
  lpmc_pkg::lpmc_state_e next_state;
  logic [11:0] recCount;
  logic [15:0] wakeVector;

  wire stopEnable    = configRegOne[lpmc_pkg::CFG1_STOP_EN];
  wire shortRecSel   = configRegOne[lpmc_pkg::CFG1_SHORT_REC];
  wire uvStopEnable  = configRegOne[lpmc_pkg::CFG1_UV_STOP];
  wire uvResetEnable = configRegOne[lpmc_pkg::CFG1_UV_RST_EN];
  wire uvEnable      = configRegOne[lpmc_pkg::CFG1_UV_EN];
  wire wdogEnable    = configRegOne[lpmc_pkg::CFG1_WDOG_EN];
  wire extIrqMask    = irqMasks[lpmc_pkg::MSK_EXT];
  wire kbdIrqMask    = irqMasks[lpmc_pkg::MSK_KBD];

  // ************************************************************
  // APB decode
  // ************************************************************
  // Ready is registered: one wait state, high for a single cycle
  wire apbAccess = psel & penable & ~pready;
  wire apbDone   = psel & penable & pready;
  wire apbWrite  = apbDone & pwrite & ~pslverr;
  wire selCfg1   = paddr == lpmc_pkg::ADDR_CONFIG_ONE;
  wire selCfg2   = paddr == lpmc_pkg::ADDR_CONFIG_TWO;
  wire selPll    = paddr == lpmc_pkg::ADDR_PLL_CTRL;
  wire selMsk    = paddr == lpmc_pkg::ADDR_IRQ_MASKS;
  wire selStat   = paddr == lpmc_pkg::ADDR_STATUS;
  wire mapped    = selCfg1 | selCfg2 | selPll | selMsk | selStat;

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = ~mapped | (pwrite & selStat);
    if (selCfg1) begin
      next_prdata[5:0] = configRegOne;
    end else if (selCfg2) begin
      next_prdata[0] = oscRunInStop;
    end else if (selPll) begin
      next_prdata[1:0] = {pllPowerOn, baseClockSelect};
    end else if (selMsk) begin
      next_prdata[1:0] = irqMasks;
    end else if (selStat) begin
      next_prdata = {wakeVector, recCount, intMask, 1'b0, state};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= apbAccess;
      if (apbAccess) begin
        pslverr <= next_pslverr;
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      configRegOne <= lpmc_pkg::CFG1_RESET;
      oscRunInStop <= lpmc_pkg::CFG2_RESET;
      irqMasks     <= lpmc_pkg::MSK_RESET;
    end else if (apbWrite) begin
      if (selCfg1) begin
        configRegOne <= pwdata[5:0];
      end
      if (selCfg2) begin
        oscRunInStop <= pwdata[lpmc_pkg::CFG2_OSC_RUN];
      end
      if (selMsk) begin
        irqMasks <= pwdata[1:0];
      end
    end
  end

  // ************************************************************
  // Wake and reset sources
  // ************************************************************
  wire extWake   = extFall & ~extIrqMask;
  wire kbdWake   = kbdFall & ~kbdIrqMask;
  wire inStop    = state == lpmc_pkg::LPMC_STOP;
  wire inWait    = state == lpmc_pkg::LPMC_WAIT;
  wire inRecover = state == lpmc_pkg::LPMC_RECOVER;
  wire tbmWake   = tbmRollover & (~inStop | oscRunInStop);
  wire uvLive    = uvEnable & (~inStop | uvStopEnable);
  wire uvReset   = uvLive & uvResetEnable & uvLow;
  // Watchdog clock is off through stop and recovery
  wire wdogReset = wdogEnable & watchdogTimeout & ~(inStop | inRecover);
  wire anyReset  = rstLow | uvReset | wdogReset;
  wire intWake   = extWake | kbdWake | tbmWake | (inWait & periphIrq);
  wire stopGo    = stopExec & stopEnable;
  wire stopEntry = stopGo & (state == lpmc_pkg::LPMC_RUN) & ~anyReset;

  // Wake priority: external, keyboard, then timebase
  wire [15:0] irqVector = extWake ? lpmc_pkg::VEC_EXT :
                          kbdWake ? lpmc_pkg::VEC_KBD : lpmc_pkg::VEC_TBM;

  function automatic logic [11:0] recLoad(input logic shortSel);
    recLoad = shortSel ? lpmc_pkg::REC_SHORT_LOAD : lpmc_pkg::REC_LONG_LOAD;
  endfunction : recLoad

  function automatic logic deepState(input lpmc_pkg::lpmc_state_e s);
    deepState = (s == lpmc_pkg::LPMC_STOP) | (s == lpmc_pkg::LPMC_RECOVER);
  endfunction : deepState

  // ************************************************************
  // Power state machine
  // ************************************************************
  // Stop is taken only from run; a reset source keeps run
  always_comb begin
    next_state = state;
    case (state)
      lpmc_pkg::LPMC_RUN: begin
        if (anyReset) begin
          next_state = lpmc_pkg::LPMC_RUN;
        end else if (stopGo) begin
          next_state = lpmc_pkg::LPMC_STOP;
        end else if (waitExec) begin
          next_state = lpmc_pkg::LPMC_WAIT;
        end
      end
      lpmc_pkg::LPMC_WAIT: begin
        if (anyReset | intWake) begin
          next_state = lpmc_pkg::LPMC_RUN;
        end
      end
      lpmc_pkg::LPMC_STOP: begin
        if (anyReset | intWake) begin
          next_state = lpmc_pkg::LPMC_RECOVER;
        end
      end
      lpmc_pkg::LPMC_RECOVER: begin
        if (recCount == 12'h000) begin
          next_state = lpmc_pkg::LPMC_RUN;
        end
      end
      default: begin
        next_state = lpmc_pkg::LPMC_RUN;
      end
    endcase
  end

  logic resetExit;

  always_ff @(posedge clk) begin
    if (srst) begin
      state      <= lpmc_pkg::LPMC_RUN;
      recCount   <= 12'h000;
      resetExit  <= 1'b0;
      wakeVector <= lpmc_pkg::VEC_RESET;
    end else begin
      state <= next_state;
      if (inStop & (anyReset | intWake)) begin
        recCount   <= recLoad(shortRecSel);
        resetExit  <= anyReset;
        wakeVector <= anyReset ? lpmc_pkg::VEC_RESET : irqVector;
      end else if (recCount != 12'h000) begin
        recCount <= recCount - 12'h001;
      end
      // A reset source during recovery still ends stop as a reset
      if (inRecover & anyReset) begin
        resetExit  <= 1'b1;
        wakeVector <= lpmc_pkg::VEC_RESET;
      end
    end
  end

  // ************************************************************
  // Interrupt mask, reset and vector outputs
  // ************************************************************
  wire recDone   = inRecover & (recCount == 12'h000);
  wire byReset   = resetExit | anyReset;
  wire waitWake  = inWait & (anyReset | intWake);
  wire runReset  = (state == lpmc_pkg::LPMC_RUN) & anyReset;
  wire resetFire = runReset | (inWait & anyReset) | (recDone & byReset);
  wire vecFire   = runReset | waitWake | recDone;
  // Reset has priority over every wake vector
  wire [15:0] vecNow = anyReset ? lpmc_pkg::VEC_RESET :
                       recDone ? wakeVector : irqVector;

  always_ff @(posedge clk) begin
    if (srst) begin
      intMask     <= 1'b1;
      deviceReset <= 1'b0;
      vectorValid <= 1'b0;
      vectorAddr  <= lpmc_pkg::VEC_RESET;
      serialReset <= 1'b0;
    end else begin
      deviceReset <= resetFire;
      serialReset <= recDone & byReset;
      vectorValid <= vecFire;
      if (vecFire) begin
        vectorAddr <= vecNow;
      end
      // Reset wins over a clear in the same cycle
      if (resetFire) begin
        intMask <= 1'b1;
      end else if (waitExec | stopGo) begin
        intMask <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Clock generator control
  // ************************************************************
  // Stop entry clears the select bit ahead of a software write
  wire pllWrite = apbWrite & selPll;

  always_ff @(posedge clk) begin
    if (srst) begin
      baseClockSelect <= lpmc_pkg::PLL_RESET[lpmc_pkg::PLL_BASE_SEL];
      pllPowerOn      <= lpmc_pkg::PLL_RESET[lpmc_pkg::PLL_POWER_ON];
    end else if (stopEntry) begin
      baseClockSelect <= 1'b0;
      pllPowerOn      <= pllPowerOn;
    end else if (pllWrite) begin
      baseClockSelect <= pwdata[lpmc_pkg::PLL_BASE_SEL];
      pllPowerOn      <= pwdata[lpmc_pkg::PLL_POWER_ON];
    end
  end

  // ************************************************************
  // Gating and peripheral enables
  // ************************************************************
  wire nStop    = next_state == lpmc_pkg::LPMC_STOP;
  wire nWait    = next_state == lpmc_pkg::LPMC_WAIT;
  wire nRecover = next_state == lpmc_pkg::LPMC_RECOVER;
  wire nDeep    = deepState(next_state);
  wire nRun     = next_state == lpmc_pkg::LPMC_RUN;

  // Enables change only at rising edges, so downstream low-phase
  // latched gates see them settled before the next high phase.
  always_ff @(posedge clk) begin
    if (srst) begin
      coreClkEn       <= 1'b1;
      busClkEn        <= 1'b1;
      oscEnable       <= 1'b1;
      pllEnable       <= 1'b0;
      genClocksOn     <= 1'b1;
      watchdogClkEn   <= 1'b1;
      prescaleClear   <= 1'b0;
      converterActive <= 1'b1;
      converterAbort  <= 1'b0;
      timebaseActive  <= 1'b1;
      timebaseAccess  <= 1'b1;
      timerRun        <= 1'b1;
      serialRun       <= 1'b1;
    end else begin
      coreClkEn       <= nRun;
      busClkEn        <= ~nDeep | (oscRunInStop & ~nRecover);
      oscEnable       <= ~nStop | oscRunInStop;
      pllEnable       <= pllPowerOn & ~nDeep;
      genClocksOn     <= ~nStop | oscRunInStop;
      watchdogClkEn   <= ~nDeep;
      prescaleClear   <= nStop & ~inStop;
      converterActive <= ~nDeep;
      converterAbort  <= nStop & ~inStop;
      timebaseActive  <= ~nDeep | oscRunInStop;
      timebaseAccess  <= nRun;
      timerRun        <= ~nDeep;
      serialRun       <= ~nDeep;
    end
  end

endmodule : low_power_mode_control

// [testbench/lpmc_props.sv]
// Port checker for the low-power mode controller
`timescale 1ns/1ps

module lpmc_props (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        waitExec,
  input wire logic        coreClkEn,
  input wire logic        busClkEn,
  input wire logic        oscEnable,
  input wire logic        pllEnable,
  input wire logic        genClocksOn,
  input wire logic        watchdogClkEn,
  input wire logic        prescaleClear,
  input wire logic        converterAbort,
  input wire logic        converterActive,
  input wire logic        timerRun,
  input wire logic        serialRun,
  input wire logic        timebaseAccess,
  input wire logic        deviceReset,
  input wire logic        intMask,
  input wire logic        vectorValid,
  input wire logic [15:0] vectorAddr,
  input wire logic        baseClockSelect
);
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_wait_core_off: assert property (
    waitExec && coreClkEn |=> deviceReset || (!coreClkEn && busClkEn && !intMask))
    else $error("wait entry wrong");
  a_tbm_access: assert property (timebaseAccess == coreClkEn)
    else $error("timebase access outside run");
  a_deep_off: assert property (
    !oscEnable |-> !genClocksOn && !pllEnable && !busClkEn) else $error("clocks alive, osc off");
  a_stop_outs: assert property (!timerRun |-> !pllEnable && !converterActive &&
    !serialRun && !watchdogClkEn && !coreClkEn) else $error("unit active in stop");
  a_entry_pulse: assert property (
    prescaleClear |-> converterAbort ##1 (!prescaleClear && !timerRun))
    else $error("stop entry pulses wrong");
  a_base_clear: assert property (prescaleClear |-> ##[0:1] !baseClockSelect)
    else $error("base clock select kept");
  a_vec_legal: assert property (vectorValid |-> vectorAddr inside
    {16'hfffe, 16'hfffa, 16'hffe0, 16'hffdc}) else $error("bad wake vector");
  a_reset_mask: assert property (deviceReset |-> ##[0:1]
    (intMask && vectorAddr == lpmc_pkg::VEC_RESET)) else $error("reset wake wrong");

  c_stop: cover property (prescaleClear);
  c_reset: cover property (deviceReset);
  c_tbm: cover property (vectorValid && vectorAddr == lpmc_pkg::VEC_TBM);
endmodule : lpmc_props

bind low_power_mode_control lpmc_props u_props (.*);

// [testbench/lpmc_core_model.sv]
// Core stand-in that executes low-power instructions and fetches vectors
`timescale 1ns/1ps

module lpmc_core_model (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        reqWait,
  input wire logic        reqStop,
  input wire logic        coreClkEn,
  input wire logic        vectorValid,
  input wire logic [15:0] vectorAddr,
  output logic            waitExec,
  output logic            stopExec,
  output logic     [15:0] fetchedVec
);
  // Instructions only execute while the core clock runs
  always_ff @(posedge clk) begin
    waitExec <= reqWait && coreClkEn && !srst;
    stopExec <= reqStop && coreClkEn && !srst;
    if (srst) fetchedVec <= 16'h0000;
    else if (vectorValid) fetchedVec <= vectorAddr;
  end
endmodule : lpmc_core_model

// [testbench/low_power_mode_control_bench.sv]
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps

module low_power_mode_control_bench;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, a;
  logic [31:0] pwdata, prdata, rdv, d, seed;
  logic        waitExec, stopExec, extIrqPin, rstPin_n, lowVoltage, tbmRollover, periphIrq;
  logic [3:0]  kbdPins;
  logic        watchdogTimeout, coreClkEn, busClkEn, oscEnable, pllEnable, genClocksOn;
  logic        watchdogClkEn, prescaleClear, converterActive, converterAbort, timebaseActive;
  logic        timebaseAccess, timerRun, serialRun, serialReset, deviceReset, intMask;
  logic        vectorValid, baseClockSelect, pllPowerOn, reqWait, reqStop, sawRst, sawSer;
  logic [15:0] vectorAddr, fetchedVec;
  int          failures, numChecks, cyc, n;

  low_power_mode_control dut (.*);
  lpmc_core_model core (.*);

  // ************************************************************
  // Clock, watchdog of the run, reset observers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (deviceReset === 1'b1) sawRst <= 1'b1;
    if (serialReset === 1'b1) sawSer <= 1'b1;
    if (cyc == 20000) begin
      failures++;
      testDone();
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task chkBit(input string nm, input logic e, input logic s);
    numChecks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
    end
  endtask : chkBit

  task chkWord(input string nm, input logic [31:0] e, input logic [31:0] s);
    numChecks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chkWord

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function logic [31:0] rmask(input logic [7:0] ad);
    if (ad == lpmc_pkg::ADDR_CONFIG_ONE) return 32'h0000003f;
    if (ad == lpmc_pkg::ADDR_CONFIG_TWO) return 32'h00000001;
    return 32'h00000003;
  endfunction : rmask

  function logic [31:0] outs();
    return {23'h0, busClkEn, oscEnable, genClocksOn, pllEnable, timebaseActive,
            timerRun, converterActive, watchdogClkEn, serialRun};
  endfunction : outs

  task tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task instr(input logic s);
    @(posedge clk);
    if (s) reqStop <= 1'b1;
    else reqWait <= 1'b1;
    @(posedge clk);
    reqStop <= 1'b0;
    reqWait <= 1'b0;
    tick(3);
  endtask : instr

  task runWait();
    n = 0;
    while (coreClkEn !== 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
  endtask : runWait

  task stopReset(input logic pin);
    sawRst <= 1'b0;
    sawSer <= 1'b0;
    instr(1'b1);
    if (pin) rstPin_n <= 1'b0;
    else lowVoltage <= 1'b1;
    tick(4);
    rstPin_n <= 1'b1;
    lowVoltage <= 1'b0;
    runWait();
    tick(2);
    chkBit("reset wake", 1'b1, sawRst);
    chkBit("serial reset", 1'b1, sawSer);
    chkBit("mask set", 1'b1, intMask);
    chkWord("reset vec", {16'h0, lpmc_pkg::VEC_RESET}, {16'h0, fetchedVec});
  endtask : stopReset

  task testDone();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : testDone

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, reqWait, reqStop, sawRst, sawSer} = '0;
    {lowVoltage, tbmRollover, periphIrq, watchdogTimeout} = '0;
    {extIrqPin, rstPin_n, kbdPins, srst} = 7'h7f;
    seed = 32'h00000029;
    failures = 0;
    numChecks = 0;
    tick(2);
    srst <= 1'b0;
    apb(1'b0, lpmc_pkg::ADDR_CONFIG_ONE, 32'h0);
    chkWord("cfg1 reset", {26'h0, lpmc_pkg::CFG1_RESET}, rdv);
    apb(1'b0, 8'h14, 32'h0);
    chkBit("unmapped", 1'b1, er);
    apb(1'b1, lpmc_pkg::ADDR_STATUS, 32'hffffffff);
    chkBit("status ro", 1'b1, er);
    for (int i = 0; i < 8; i++) begin
      a = {4'h0, 2'(i), 2'b00};
      d = xs();
      apb(1'b1, a, d);
      apb(1'b0, a, 32'h0);
      chkWord("reg rw", d & rmask(a), rdv);
    end
    for (int i = 0; i < 4; i++) apb(1'b1, {4'h0, 2'(i), 2'b00}, 32'h0);
    instr(1'b1);
    chkBit("stop ignored", 1'b1, coreClkEn);
    instr(1'b0);
    chkWord("wait outs", 32'h000001df, outs());
    chkBit("wait access", 1'b0, timebaseAccess);
    chkBit("wait mask", 1'b0, intMask);
    tbmRollover <= 1'b1;
    tick(1);
    tbmRollover <= 1'b0;
    runWait();
    tick(2);
    chkWord("tbm vec", {16'h0, lpmc_pkg::VEC_TBM}, {16'h0, fetchedVec});
    chkBit("mask kept", 1'b0, intMask);
    instr(1'b0);
    periphIrq <= 1'b1;
    runWait();
    periphIrq <= 1'b0;
    chkBit("irq wake", 1'b1, n < 10);
    apb(1'b1, lpmc_pkg::ADDR_CONFIG_ONE, 32'h30);
    sawRst <= 1'b0;
    instr(1'b0);
    watchdogTimeout <= 1'b1;
    tick(1);
    watchdogTimeout <= 1'b0;
    tick(3);
    chkBit("wdog reset", 1'b1, sawRst);
    apb(1'b1, lpmc_pkg::ADDR_CONFIG_ONE, 32'h01);
    apb(1'b1, lpmc_pkg::ADDR_PLL_CTRL, 32'h03);
    apb(1'b1, lpmc_pkg::ADDR_IRQ_MASKS, 32'h01);
    instr(1'b1);
    chkWord("stop outs", 32'h0, outs());
    extIrqPin <= 1'b0;
    tick(20);
    chkBit("ext masked", 1'b0, coreClkEn);
    kbdPins <= 4'he;
    runWait();
    chkBit("long recovery", 1'b1, n >= 4096 && n <= 4106);
    tick(2);
    chkWord("kbd vec", {16'h0, lpmc_pkg::VEC_KBD}, {16'h0, fetchedVec});
    chkBit("mask clear", 1'b0, intMask);
    extIrqPin <= 1'b1;
    kbdPins <= 4'hf;
    apb(1'b0, lpmc_pkg::ADDR_PLL_CTRL, 32'h0);
    chkBit("base select", 1'b0, rdv[0]);
    chkBit("pll power kept", 1'b1, pllPowerOn);
    apb(1'b1, lpmc_pkg::ADDR_IRQ_MASKS, 32'h0);
    apb(1'b1, lpmc_pkg::ADDR_CONFIG_TWO, 32'h01);
    apb(1'b1, lpmc_pkg::ADDR_CONFIG_ONE, 32'h03);
    instr(1'b1);
    chkWord("kept outs", 32'h000001d0, outs());
    extIrqPin <= 1'b0;
    runWait();
    chkBit("short recovery", 1'b1, n >= 32 && n <= 42);
    tick(2);
    chkWord("ext vec", {16'h0, lpmc_pkg::VEC_EXT}, {16'h0, fetchedVec});
    extIrqPin <= 1'b1;
    instr(1'b1);
    tbmRollover <= 1'b1;
    tick(1);
    tbmRollover <= 1'b0;
    runWait();
    tick(2);
    chkWord("stop tbm vec", {16'h0, lpmc_pkg::VEC_TBM}, {16'h0, fetchedVec});
    stopReset(1'b1);
    apb(1'b1, lpmc_pkg::ADDR_CONFIG_ONE, 32'h1d);
    stopReset(1'b0);
    testDone();
  end
endmodule : low_power_mode_control_bench
